//--- rtl/csr_card.v
// Card command interpreter: state table and serial reply formatter
// Contract
// - Next state comes from the table of current state versus command and condition.
// - In interrupt-wait any command, even faulty, goes to standby.
// - Index 1 in idle: ready when range matches, idle while powering up.
// - Index 1 in idle with incompatible window: shut-out, leave the bus.
// - Index 2 in ready: winner to card-naming, loser stays ready.
// - Index 7 addressed: standby to block-op, deselected-prog to programming.
// - Index 7 not addressed: block-op or data to standby, prog to deselected.
// - Replies go out on the command line most significant bit first.
// - Replies start with 0 then direction bit 0.
// - Every reply ends with a 1.
// - All replies carry CRC except the conditions reply.
// - Short status reply is 48 bits, index in bits 45 to 40.
// - Status in bits 39 to 8, CRC7 in bits 7 to 1.
// - Status-with-busy reply equals short reply, busy follows on data line.
// - Long reply is 136 bits, bits 133 to 128 all ones.
// - Identity register answers index 2 and 10.
// - Card-specific data register answers index 9.
// - Long reply carries register bits 127 to 1, bit 0 becomes end bit.
// - Index 1 answered by conditions reply: ones, register, ones.
// - Only these three reply formats are ever generated.
// - Register bit 31 low during power-up; bits 8 to 23 flag windows.
`timescale 1ns/1ps
`include "csr_defs.vh"
module csr_card #(
   parameter [15:0] RCA = 16'h0001,
   parameter [23:0] VDD_WINDOWS = 24'hFF_8000
) (
   input wire i_clk,
   input wire i_reset,
   input wire i_link_clk,
   input wire i_cmd_in,
   input wire i_pwr_done,
   input wire i_busy,
   input wire [127:0] i_card_identity_register,
   input wire [127:0] i_card_specific_data_register,
   input wire [31:0] i_status,
   output reg o_cmd_out,
   output reg o_cmd_oe,
   output reg o_dat0_out,
   output reg o_dat0_oe,
   output reg [3:0] o_state,
   output reg o_cmd_err
);
////////////////////////////////////////////////////////////////////////
// Input synchronisers; first stage is read only by the second
reg [1:0] clk_sync_ff;
reg [1:0] cmd_sync_ff;
reg [1:0] busy_sync_ff;
reg [1:0] pwr_sync_ff;
reg clk_prev_ff;
always @(posedge i_clk) begin
   if (i_reset) begin
      clk_sync_ff <= 2'b00;
      cmd_sync_ff <= 2'b11;
      busy_sync_ff <= 2'b00;
      pwr_sync_ff <= 2'b00;
      clk_prev_ff <= 1'b0;
   end else begin
      clk_sync_ff <= {clk_sync_ff[0], i_link_clk};
      cmd_sync_ff <= {cmd_sync_ff[0], i_cmd_in};
      busy_sync_ff <= {busy_sync_ff[0], i_busy};
      pwr_sync_ff <= {pwr_sync_ff[0], i_pwr_done};
      clk_prev_ff <= clk_sync_ff[1];
   end
end
// Host samples on rising edge, card drives after falling edge
wire rise = clk_sync_ff[1] & ~clk_prev_ff;
wire fall = ~clk_sync_ff[1] & clk_prev_ff;
wire cmd_bit = cmd_sync_ff[1];
wire pwr_done = pwr_sync_ff[1];
////////////////////////////////////////////////////////////////////////
// CRC7 step, polynomial x^7 + x^3 + 1
function [6:0] crc7_step;
   input [6:0] c;
   input b;
   reg fb;
   begin
      fb = c[6] ^ b;
      crc7_step = {c[5:3], c[2] ^ fb, c[1:0], fb};
   end
endfunction
////////////////////////////////////////////////////////////////////////
// Command receiver
localparam RX_IDLE = 1'b0;
localparam RX_BODY = 1'b1;
reg rx_st_ff;
reg [7:0] rx_cnt_ff;
reg [46:0] rx_sh_ff;
reg [6:0] rx_crc_ff;
reg cmd_done_ff;
reg crc_ok_ff;
always @(posedge i_clk) begin
   if (i_reset) begin
      rx_st_ff <= RX_IDLE;
      rx_cnt_ff <= 8'h00;
      rx_sh_ff <= 47'h0;
      rx_crc_ff <= 7'h00;
      cmd_done_ff <= 1'b0;
      crc_ok_ff <= 1'b0;
   end else begin
      cmd_done_ff <= 1'b0;
      if (rise && !o_cmd_oe) begin
         case (rx_st_ff)
            RX_IDLE: begin
               // Start bit begins a frame
               if (!cmd_bit) begin
                  rx_st_ff <= RX_BODY;
                  rx_cnt_ff <= 8'd1;
                  rx_sh_ff <= 47'h0;
                  rx_crc_ff <= crc7_step(7'h00, 1'b0);
               end
            end
            RX_BODY: begin
               rx_sh_ff <= {rx_sh_ff[45:0], cmd_bit};
               rx_cnt_ff <= rx_cnt_ff + 8'd1;
               if (rx_cnt_ff < 8'd40) begin
                  rx_crc_ff <= crc7_step(rx_crc_ff, cmd_bit);
               end
               if (rx_cnt_ff == `CSR_CMD_LEN - 8'd1) begin
                  rx_st_ff <= RX_IDLE;
                  cmd_done_ff <= 1'b1;
                  // Direction bit 1, CRC match, end bit 1
                  crc_ok_ff <= rx_sh_ff[45] & (rx_sh_ff[6:0] == rx_crc_ff) & cmd_bit;
               end
            end
            default: rx_st_ff <= RX_IDLE;
         endcase
      end
   end
end
// Once the end bit has shifted in, frame bit k sits at position k
wire [5:0] rx_idx = rx_sh_ff[45:40];
wire [31:0] rx_arg = rx_sh_ff[39:8];
////////////////////////////////////////////////////////////////////////
// Card-local state: address, power-up conditions register
reg [15:0] rca_ff;
wire [31:0] cond_reg = {pwr_done, 7'h00, VDD_WINDOWS[23:8], 8'h00};
wire addressed = (rx_arg[31:16] == rca_ff);
// Identification contention modelled as always winning against no peer
wire wins_bus = 1'b1;
////////////////////////////////////////////////////////////////////////
// Next-state and reply-kind decode
reg [3:0] nxt_state;
reg [1:0] nxt_kind;
reg nxt_busy;
always @* begin
   nxt_state = o_state;
   nxt_kind = `CSR_RK_SHORT;
   nxt_busy = 1'b0;
   if (o_state == `CSR_ST_IRQ) begin
      nxt_state = `CSR_ST_STBY;
      nxt_kind = `CSR_RK_NONE;
   end else if (!crc_ok_ff || o_state == `CSR_ST_INA) begin
      nxt_kind = `CSR_RK_NONE;
   end else begin
      case (rx_idx)
         6'd0: begin
            nxt_state = `CSR_ST_IDLE;
            nxt_kind = `CSR_RK_NONE;
         end
         6'd1: begin
            if (o_state == `CSR_ST_IDLE) begin
               nxt_kind = `CSR_RK_COND;
               if ((rx_arg[23:8] & VDD_WINDOWS[23:8]) == 16'h0000)
                  nxt_state = `CSR_ST_INA;
               else if (pwr_done)
                  nxt_state = `CSR_ST_READY;
            end else
               nxt_kind = `CSR_RK_NONE;
         end
         6'd2: begin
            if (o_state == `CSR_ST_READY) begin
               nxt_kind = `CSR_RK_LONG;
               if (wins_bus)
                  nxt_state = `CSR_ST_IDENT;
            end else
               nxt_kind = `CSR_RK_NONE;
         end
         6'd3: begin
            if (o_state == `CSR_ST_IDENT)
               nxt_state = `CSR_ST_STBY;
            else
               nxt_kind = `CSR_RK_NONE;
         end
         6'd4: nxt_kind = `CSR_RK_NONE;
         6'd7: begin
            if (addressed) begin
               nxt_busy = (o_state == `CSR_ST_DIS);
               if (o_state == `CSR_ST_STBY)
                  nxt_state = `CSR_ST_TRAN;
               else if (o_state == `CSR_ST_DIS)
                  nxt_state = `CSR_ST_PRG;
               else
                  nxt_kind = `CSR_RK_NONE;
            end else begin
               nxt_kind = `CSR_RK_NONE;
               if (o_state == `CSR_ST_TRAN || o_state == `CSR_ST_DATA)
                  nxt_state = `CSR_ST_STBY;
               else if (o_state == `CSR_ST_PRG)
                  nxt_state = `CSR_ST_DIS;
            end
         end
         6'd9, 6'd10: begin
            if (o_state == `CSR_ST_STBY && addressed)
               nxt_kind = `CSR_RK_LONG;
            else
               nxt_kind = `CSR_RK_NONE;
         end
         6'd12: begin
            nxt_busy = 1'b1;
            if (o_state == `CSR_ST_DATA)
               nxt_state = `CSR_ST_TRAN;
            else if (o_state == `CSR_ST_RCV)
               nxt_state = `CSR_ST_PRG;
            else
               nxt_kind = `CSR_RK_NONE;
         end
         6'd13: begin
            if (o_state == `CSR_ST_IDLE || o_state == `CSR_ST_READY ||
                o_state == `CSR_ST_IDENT || !addressed)
               nxt_kind = `CSR_RK_NONE;
         end
         6'd15: begin
            nxt_kind = `CSR_RK_NONE;
            if (o_state >= `CSR_ST_STBY && o_state <= `CSR_ST_DIS && addressed)
               nxt_state = `CSR_ST_INA;
         end
         6'd11, 6'd17, 6'd18, 6'd30: begin
            if (o_state == `CSR_ST_TRAN)
               nxt_state = `CSR_ST_DATA;
            else
               nxt_kind = `CSR_RK_NONE;
         end
         6'd20, 6'd24, 6'd25, 6'd26, 6'd27: begin
            if (o_state == `CSR_ST_TRAN || (o_state == `CSR_ST_PRG && rx_idx[4:1] == 4'hC))
               nxt_state = `CSR_ST_RCV;
            else
               nxt_kind = `CSR_RK_NONE;
         end
         6'd28, 6'd29, 6'd38: begin
            nxt_busy = 1'b1;
            if (o_state == `CSR_ST_TRAN)
               nxt_state = `CSR_ST_PRG;
            else
               nxt_kind = `CSR_RK_NONE;
         end
         6'd16, 6'd32, 6'd33, 6'd34, 6'd35, 6'd36, 6'd37: begin
            if (o_state != `CSR_ST_TRAN)
               nxt_kind = `CSR_RK_NONE;
         end
         default: nxt_kind = `CSR_RK_NONE;
      endcase
   end
end
////////////////////////////////////////////////////////////////////////
// Reply transmitter; frame loaded MSB-aligned into a 136-bit shifter
localparam TX_IDLE = 2'h0;
localparam TX_GAP = 2'h1;
localparam TX_SEND = 2'h2;
localparam TX_BUSY = 2'h3;
reg [1:0] tx_st_ff;
reg [135:0] tx_sh_ff;
reg [7:0] tx_cnt_ff;
reg [3:0] gap_ff;
reg [1:0] tx_kind_ff;
reg busy_pend_ff;
reg [6:0] tx_crc_ff;
reg [7:0] tx_len;
always @* begin
   case (tx_kind_ff)
      `CSR_RK_LONG: tx_len = `CSR_LONG_LEN;
      default: tx_len = `CSR_SHORT_LEN;
   endcase
end
// Bit positions where CRC replaces payload, counted from the frame start
wire in_crc = (tx_kind_ff == `CSR_RK_SHORT) && (tx_cnt_ff >= 8'd40) && (tx_cnt_ff < 8'd47);
always @(posedge i_clk) begin
   if (i_reset) begin
      o_state <= `CSR_ST_IDLE;
      o_cmd_err <= 1'b0;
      rca_ff <= RCA;
      tx_st_ff <= TX_IDLE;
      tx_sh_ff <= 136'h0;
      tx_cnt_ff <= 8'h00;
      gap_ff <= 4'h0;
      tx_kind_ff <= `CSR_RK_NONE;
      busy_pend_ff <= 1'b0;
      tx_crc_ff <= 7'h00;
      o_cmd_out <= 1'b1;
      o_cmd_oe <= 1'b0;
      o_dat0_out <= 1'b1;
      o_dat0_oe <= 1'b0;
   end else begin
      if (cmd_done_ff) begin
         o_state <= nxt_state;
         o_cmd_err <= ~crc_ok_ff;
         tx_kind_ff <= nxt_kind;
         busy_pend_ff <= nxt_busy;
         tx_crc_ff <= 7'h00;
         tx_cnt_ff <= 8'h00;
         gap_ff <= `CSR_NCR_CLK;
         case (nxt_kind)
            `CSR_RK_SHORT: tx_sh_ff <= {2'b00, rx_idx, i_status, 7'h00, 1'b1, 88'h0};
            `CSR_RK_LONG: tx_sh_ff <= {2'b00, `CSR_LONG_RSV,
               ((rx_idx == 6'd9) ? i_card_specific_data_register[127:1] :
               i_card_identity_register[127:1]), 1'b1};
            `CSR_RK_COND: tx_sh_ff <= {2'b00, `CSR_COND_IDX, cond_reg, `CSR_COND_CRC, 1'b1,
               88'h0};
            default: tx_sh_ff <= 136'h0;
         endcase
         if (nxt_kind != `CSR_RK_NONE)
            tx_st_ff <= TX_GAP;
      end else if (tx_st_ff == TX_BUSY) begin
         // Busy runs on the system clock, since the host may stop the link clock
         o_dat0_oe <= 1'b1;
         o_dat0_out <= 1'b0;
         if (!busy_sync_ff[1] && o_dat0_oe) begin
            o_dat0_oe <= 1'b0;
            o_dat0_out <= 1'b1;
            tx_st_ff <= TX_IDLE;
         end
      end else if (fall) begin
         case (tx_st_ff)
            TX_GAP: begin
               gap_ff <= gap_ff - 4'd1;
               if (gap_ff == 4'd1)
                  tx_st_ff <= TX_SEND;
            end
            TX_SEND: begin
               o_cmd_oe <= 1'b1;
               // MSB first; CRC shifted out in place of the zero field
               o_cmd_out <= in_crc ? tx_crc_ff[6] : tx_sh_ff[135];
               if (in_crc)
                  tx_crc_ff <= {tx_crc_ff[5:0], 1'b0};
               else if (tx_cnt_ff < 8'd40)
                  tx_crc_ff <= crc7_step(tx_crc_ff, tx_sh_ff[135]);
               tx_sh_ff <= {tx_sh_ff[134:0], 1'b0};
               tx_cnt_ff <= tx_cnt_ff + 8'd1;
               if (tx_cnt_ff == tx_len) begin
                  // One fall past the end bit releases the line
                  o_cmd_oe <= 1'b0;
                  o_cmd_out <= 1'b1;
                  tx_st_ff <= busy_pend_ff ? TX_BUSY : TX_IDLE;
               end
            end
            default: tx_st_ff <= TX_IDLE;
         endcase
      end
   end
end
endmodule

//--- rtl/csr_defs.vh
// Constants for the card state and response logic
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH
// Card protocol states
`define CSR_ST_IDLE 4'h0
`define CSR_ST_READY 4'h1
`define CSR_ST_IDENT 4'h2
`define CSR_ST_STBY 4'h3
`define CSR_ST_TRAN 4'h4
`define CSR_ST_DATA 4'h5
`define CSR_ST_RCV 4'h6
`define CSR_ST_PRG 4'h7
`define CSR_ST_DIS 4'h8
`define CSR_ST_INA 4'h9
`define CSR_ST_IRQ 4'hA
// Reply kinds
`define CSR_RK_NONE 2'h0
`define CSR_RK_SHORT 2'h1
`define CSR_RK_LONG 2'h2
`define CSR_RK_COND 2'h3
// Frame lengths
`define CSR_CMD_LEN 8'd48
`define CSR_SHORT_LEN 8'd48
`define CSR_LONG_LEN 8'd136
// Field values
`define CSR_LONG_RSV 6'h3F
`define CSR_COND_IDX 6'h3F
`define CSR_COND_CRC 7'h7F
`define CSR_COND_REG_PWR_BIT 31
`define CSR_COND_REG_WIN_HI 23
`define CSR_COND_REG_WIN_LO 8
// Gap between command end bit and reply start, in link clocks
`define CSR_NCR_CLK 4'd2
`endif

//--- tb/csr_card_properties.sv
// Concurrent checks on the card command and data line drive
`timescale 1ns/1ps
module csr_card_props (
   input wire i_clk,
   input wire i_reset,
   input wire i_busy,
   input wire o_cmd_out,
   input wire o_cmd_oe,
   input wire o_dat0_out,
   input wire o_dat0_oe,
   input wire [3:0] o_state
);
   int unsigned run_cnt;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////////////////
   // Cycles the card has held the command line; replies have fixed lengths
   always_ff @(posedge i_clk) begin
      if (i_reset || !o_cmd_oe) begin
         run_cnt <= 0;
      end else begin
         run_cnt <= run_cnt + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Interrupt-wait is never entered, so the codes stop at shut-out
   property p_state_range;
      o_state <= 4'h9;
   endproperty
   a_state_range: assert property (p_state_range)
      else $error("state code outside the reachable set");
   // No command is decoded while a reply is going out
   property p_state_hold;
      o_cmd_oe |=> $stable(o_state);
   endproperty
   a_state_hold: assert property (p_state_hold)
      else $error("state moved during a reply");
   // Start and direction bits are both low, one link clock each
   property p_start_dir;
      $rose(o_cmd_oe) |-> (!o_cmd_out) [*8] ##1 (!o_cmd_out) [*7];
   endproperty
   a_start_dir: assert property (p_start_dir)
      else $error("reply did not open with two low bits");
   // Last driven bit is high one and six cycles before the line is released
   property p_end_bit;
      $fell(o_cmd_oe) |-> $past(o_cmd_out) && $past(o_cmd_out, 6);
   endproperty
   a_end_bit: assert property (p_end_bit)
      else $error("reply did not close with a high bit");
   // Only 48 or 136 link clocks of eight system clocks each
   property p_reply_len;
      $fell(o_cmd_oe) |-> run_cnt inside {[383:385], [1087:1089]};
   endproperty
   a_reply_len: assert property (p_reply_len)
      else $error("reply length is neither 48 nor 136 bits");
   // Shut-out is left only through reset
   property p_shut_out;
      o_state == 4'h9 |=> o_state == 4'h9;
   endproperty
   a_shut_out: assert property (p_shut_out)
      else $error("card left the shut-out state");
   // Busy on the data line is a low level
   property p_busy_low;
      o_dat0_oe |-> !o_dat0_out;
   endproperty
   a_busy_low: assert property (p_busy_low)
      else $error("data line driven high while busy");
   // Busy drive ends a few cycles after programming finishes
   property p_busy_free;
      (o_dat0_oe && !i_busy) [*6] |=> !o_dat0_oe;
   endproperty
   a_busy_free: assert property (p_busy_free)
      else $error("busy drive outlived the programming");
endmodule
bind csr_card csr_card_props u_props (.i_clk(i_clk), .i_reset(i_reset), .i_busy(i_busy),
   .o_cmd_out(o_cmd_out), .o_cmd_oe(o_cmd_oe), .o_dat0_out(o_dat0_out),
   .o_dat0_oe(o_dat0_oe), .o_state(o_state));

//--- tb/csr_host.sv
// Host controller model driving the card command bus
`timescale 1ns/1ps
module csr_host (
   input wire i_cmd_out,
   input wire i_cmd_oe,
   output logic o_link_clk,
   output logic o_cmd_in
);
   logic host_oe = 1'b0;
   logic host_bit = 1'b1;
   initial o_link_clk = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // Command wire has a pull-up, so it idles high when nobody drives
   assign o_cmd_in = i_cmd_oe ? i_cmd_out : (host_oe ? host_bit : 1'b1);
   // One link period; the clock stands low between frames
   task automatic tick();
      #160 o_link_clk = 1'b1;
      #160 o_link_clk = 1'b0;
   endtask
   // Send a frame on falling edges, then clock on and gather any reply
   task automatic xfer(input logic [47:0] frame, input int len, output logic [135:0] rsp,
      output bit seen);
      int n;
      rsp = '0;
      seen = 0;
      #7;
      for (n = 47; n >= 0; n--) begin
         host_oe = 1'b1;
         host_bit = frame[n];
         tick();
      end
      host_oe = 1'b0;
      for (n = 0; n < 12 && !seen; n++) begin
         #160 o_link_clk = 1'b1;
         seen = !o_cmd_in;
         #160 o_link_clk = 1'b0;
      end
      for (n = 1; n < len && seen; n++) begin
         #160 o_link_clk = 1'b1;
         rsp = {rsp[134:0], o_cmd_in};
         #160 o_link_clk = 1'b0;
      end
      repeat (3) tick();
   endtask
endmodule

//--- tb/csr_card_bench.sv
// Self-checking bench for the card state and reply logic
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module csr_card_bench;
   localparam logic [15:0] RCA = 16'h0001;
   localparam logic [23:0] VDD = 24'hFF_8000;
   logic i_clk = 0, i_reset = 1, i_pwr_done = 0, i_busy = 0;
   logic [127:0] card_identity_register, card_specific_data_register;
   logic [31:0] i_status;
   wire link_clk, cmd_line, cmd_out, cmd_oe, dat0_out, dat0_oe, cmd_err;
   wire [3:0] state;
   int err_total = 0, total_checks = 0, exp_st = 0;
   integer seed = 17;
   logic [135:0] rsp;
   bit seen;
   csr_card #(.RCA(RCA), .VDD_WINDOWS(VDD)) dut (.i_clk(i_clk), .i_reset(i_reset),
      .i_link_clk(link_clk), .i_cmd_in(cmd_line), .i_pwr_done(i_pwr_done), .i_busy(i_busy),
      .i_card_identity_register(card_identity_register),
      .i_card_specific_data_register(card_specific_data_register),
      .i_status(i_status), .o_cmd_out(cmd_out),
      .o_cmd_oe(cmd_oe), .o_dat0_out(dat0_out), .o_dat0_oe(dat0_oe), .o_state(state),
      .o_cmd_err(cmd_err));
   csr_host host (.i_cmd_out(cmd_out), .i_cmd_oe(cmd_oe), .o_link_clk(link_clk),
      .o_cmd_in(cmd_line));
   initial forever #20 i_clk = ~i_clk;
   ////////////////////////////////////////////////////////////////////////
   // Seven-bit frame checksum, polynomial x7 + x3 + 1
   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      c = '0;
      for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
      return c;
   endfunction
   // Verdict and end of run
   task automatic test_done();
      if (err_total == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // One command: predict reply and next state, run it, compare
   task automatic cmd(input int idx, input logic [31:0] arg, input int bad);
      logic [39:0] body;
      logic [135:0] exp;
      int len, nxt;
      bit bsy;
      @(negedge i_clk);
      i_status = $random(seed);
      body = {2'b01, idx[5:0], arg};
      nxt = exp_st;
      len = 48;
      case (idx)
         0, 4, 15: len = 0;
         2, 9, 10: len = 136;
         7: len = (arg[31:16] == RCA) ? 48 : 0;
         default: ;
      endcase
      case (idx)
         0: nxt = 0;
         1: nxt = ((arg[23:0] & VDD) == 0) ? 9 : (i_pwr_done ? 1 : 0);
         2: nxt = 2;
         3: nxt = 3;
         7: nxt = len ? (exp_st == 3 ? 4 : 7) : (exp_st == 7 ? 8 : 3);
         12: nxt = (exp_st == 5) ? 4 : 7;
         15: nxt = 9;
         17: nxt = 5;
         24: nxt = 6;
         28: nxt = 7;
         default: ;
      endcase
      // Faulty frames and a shut-out card leave state and line alone
      if (bad != 0 || exp_st == 9) begin
         len = 0;
         nxt = exp_st;
      end
      // Busy follows only a status reply that was actually sent
      bsy = len != 0 && (idx inside {12, 28} || (idx == 7 && exp_st == 8));
      exp = {2'b00, idx[5:0], i_status, 8'h01};
      exp[7:1] = crc7(exp[47:8]);
      if (idx == 1) exp = {2'b00, 6'h3F, i_pwr_done, 7'h00, VDD, 8'hFF};
      if (len == 136)
         exp = {2'b00, 6'h3F, (idx == 9) ? card_specific_data_register[127:1] :
            card_identity_register[127:1], 1'b1};
      i_busy = bsy;
      host.xfer({body, crc7(body) ^ bad[6:0], 1'b1}, len, rsp, seen);
      `CHK("reply present", len != 0, seen)
      if (len != 0) `CHK("reply bits", exp, rsp)
      @(negedge i_clk);
      `CHK("state", nxt[3:0], state)
      `CHK("fault flag", bad != 0, cmd_err)
      // Host waits for the busy level to clear before moving on
      if (bsy) begin
         `CHK("busy drive", 2'b10, {dat0_oe, dat0_out})
         i_busy = 0;
         repeat (8) @(negedge i_clk);
         `CHK("busy release", 1'b0, dat0_oe)
      end else begin
         `CHK("no busy", 1'b0, dat0_oe)
      end
      exp_st = nxt;
   endtask
   // Main sequence through identification, transfer and shut-out
   initial begin
      card_identity_register = {$random(seed), $random(seed), $random(seed), $random(seed)};
      card_specific_data_register = {$random(seed), $random(seed), $random(seed),
         $random(seed)};
      i_status = 32'h0000_0000;
      repeat (16) @(posedge i_clk);
      @(negedge i_clk);
      i_reset = 0;
      repeat (3) @(negedge i_clk);
      `CHK("reset state", 4'h0, state)
      `CHK("reset fault", 1'b0, cmd_err)
      cmd(1, VDD, 0);
      i_pwr_done = 1;
      cmd(1, VDD, 0);
      cmd(2, 0, 0);
      cmd(3, 0, 0);
      cmd(9, {RCA, 16'h0000}, 0);
      cmd(10, {RCA, 16'h0000}, 0);
      cmd(13, {RCA, 16'h0000}, 0);
      cmd(4, 0, 0);
      cmd(7, {RCA, 16'h0000}, 0);
      cmd(32, $random(seed), 0);
      cmd(16, $random(seed), 1);
      cmd(17, $random(seed), 0);
      cmd(12, 0, 0);
      cmd(28, $random(seed), 0);
      cmd(7, ~{RCA, 16'h0000}, 0);
      cmd(7, {RCA, 16'h0000}, 0);
      cmd(24, $random(seed), 0);
      cmd(12, 0, 0);
      cmd(15, {RCA, 16'h0000}, 0);
      cmd(0, 0, 0);
      // Second reset in mid-run, then an incompatible supply window
      i_reset = 1;
      repeat (16) @(negedge i_clk);
      i_reset = 0;
      exp_st = 0;
      repeat (3) @(negedge i_clk);
      `CHK("reset state", 4'h0, state)
      cmd(1, 32'h0000_0000, 0);
      cmd(1, VDD, 0);
      test_done();
   end
   // Watchdog well beyond the expected run of about 0.7 ms
   initial begin
      #3_000_000;
      err_total++;
      test_done();
   end
endmodule
